/* rtl/scl_map.vh */
// offsets, field positions, reset values and codes for the strap latch
`ifndef SCL_MAP_VH
`define SCL_MAP_VH

// register byte offsets on the plain register port
`define SCL_ADDR_W        4
`define SCL_DATA_W        16
`define SCL_OFF_CTRL      4'h0
`define SCL_OFF_STRAP     4'h4
`define SCL_OFF_EFFECT    4'h8

// control register fields
`define SCL_CTRL_BCAST_DIS 0
`define SCL_CTRL_RESET     16'h0000

// strap register fields
`define SCL_ST_ADDR_LO    0
`define SCL_ST_ADDR_HI    2
`define SCL_ST_RX         3
`define SCL_ST_TX         4
`define SCL_ST_PLL        5
`define SCL_ST_REGDIS     6
`define SCL_ST_VOL_LO     7
`define SCL_ST_VOL_HI     8
`define SCL_ST_VALID      9

// effect register fields
`define SCL_EF_RXD_LO     0
`define SCL_EF_RXD_HI     1
`define SCL_EF_TXD        2
`define SCL_EF_REG_EN     3
`define SCL_EF_VOL_LO     4
`define SCL_EF_VOL_HI     5
`define SCL_EF_VOL_BAD    6
`define SCL_EF_PLL_OFF    7

// strap vector width, laid out as the strap register fields
`define SCL_STRAP_W       9

// receive clock speed codes
`define SCL_SPD_2M5       2'h0
`define SCL_SPD_25M       2'h1
`define SCL_SPD_125M      2'h2

// receive clock delay codes
`define SCL_RXD_NONE      2'h0
`define SCL_RXD_2NS       2'h1
`define SCL_RXD_8NS       2'h2

// io voltage codes
`define SCL_VOL_3V3       2'h0
`define SCL_VOL_2V5       2'h1
`define SCL_VOL_1V8       2'h2

// broadcast management address
`define SCL_BCAST_ADDR    5'h00

`endif

/* rtl/scl_strap_latch.v */
// strap sampling at reset release, held configuration and its decoded effects
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`include "scl_map.vh"

module scl_strap_latch (
   input  wire                    clk,
   input  wire                    rst,
   input  wire                    hardware_reset_n,
   input  wire [2:0]              mgmt_addr_strap,
   input  wire                    rx_clock_skew_strap,
   input  wire                    tx_clock_skew_strap,
   input  wire                    sleep_pll_shutdown_strap,
   input  wire                    io_regulator_disable_strap,
   input  wire [1:0]              io_voltage_select_strap,
   input  wire [2:0]              led_request,
   output reg  [2:0]              led_out,
   output reg  [2:0]              led_oe,
   input  wire [1:0]              rx_speed,
   input  wire                    sleep_mode,
   input  wire [4:0]              mgmt_frame_addr,
   input  wire                    mgmt_frame_valid,
   output reg                     mgmt_addr_hit,
   output reg                     mgmt_addr_miss,
   output reg  [2:0]              mgmt_addr,
   output reg  [1:0]              rx_clock_delay,
   output reg                     tx_clock_delay_2ns,
   output reg                     pll_shutdown,
   output reg                     io_regulator_enable,
   output reg  [1:0]              io_voltage,
   output reg                     io_voltage_invalid,
   output reg                     config_valid,
   input  wire [`SCL_ADDR_W-1:0]  reg_addr,
   input  wire [`SCL_DATA_W-1:0]  reg_wdata,
   input  wire                    reg_write,
   input  wire                    reg_read,
   output reg  [`SCL_DATA_W-1:0]  reg_rdata
);

   // receive clock delay from strap and speed
   // only the 125MHz code gets the short delay; the unused
   // speed code 3 falls to the long delay, the safer choice
   // since a slow clock tolerates extra skew
   function [1:0] rx_delay_code;
      input       strap;
      input [1:0] speed;
      begin
         if (!strap) begin
            rx_delay_code = `SCL_RXD_NONE;
         end else if (speed == `SCL_SPD_125M) begin
            rx_delay_code = `SCL_RXD_2NS;
         end else begin
            rx_delay_code = `SCL_RXD_8NS;
         end
      end
   endfunction

   // io voltage from the two-bit strap
   // both upper codes give 1.8V, so the low bit only
   // matters while the upper bit is clear
   function [1:0] vol_code;
      input [1:0] sel;
      begin
         case (sel)
            2'h0:    vol_code = `SCL_VOL_3V3;
            2'h1:    vol_code = `SCL_VOL_2V5;
            default: vol_code = `SCL_VOL_1V8;
         endcase
      end
   endfunction

   // control reset image, named so one bit can be picked out
   localparam [`SCL_DATA_W-1:0] ctrl_reset_image = `SCL_CTRL_RESET;

   // raw pin vector, all straps side by side
   // bit order is the strap register layout, so software
   // sees each pin at the same place it is held
   wire [`SCL_STRAP_W-1:0] pin_raw;          // straps as one vector
   reg  [`SCL_STRAP_W-1:0] pin_meta;         // first synchroniser stage
   reg  [`SCL_STRAP_W-1:0] pin_sync;         // second synchroniser stage
   reg                     hrst_meta;        // hw reset first stage
   reg                     hrst_sync_n;      // hw reset second stage
   reg                     capture_pending;  // a release has not been sampled yet
   reg  [`SCL_STRAP_W-1:0] strap_held;       // captured straps
   reg                     bcast_disable;    // software control bit
   wire [`SCL_DATA_W-1:0]  strap_word;       // strap register view
   wire [`SCL_DATA_W-1:0]  effect_word;      // effect register view
   reg  [`SCL_DATA_W-1:0]  next_rdata;       // read mux result
   wire                    reg_en;           // internal regulator in use
   wire [1:0]              vol_sel;          // held voltage strap
   wire                    addr_match;       // frame targets own address
   wire                    bcast_match;      // frame targets broadcast

   // gather the straps into one vector so a single loop can
   // synchronise them and one register can hold them
   assign pin_raw = {io_voltage_select_strap,
                     io_regulator_disable_strap,
                     sleep_pll_shutdown_strap,
                     tx_clock_skew_strap,
                     rx_clock_skew_strap,
                     mgmt_addr_strap};

   // two-stage synchronisers, straps come from board pins
   // pins settle slowly through resistors, so a metastable
   // first stage is expected near the release edge; only
   // the second stage is read by any logic
   genvar gi;
   generate
      for (gi = 0; gi < `SCL_STRAP_W; gi = gi + 1) begin : g_sync
         always @(posedge clk) begin
            if (rst) begin
               pin_meta[gi] <= 1'b0;
               pin_sync[gi] <= 1'b0;
            end else begin
               pin_meta[gi] <= pin_raw[gi];
               pin_sync[gi] <= pin_meta[gi];
            end
         end
      end
   endgenerate

   // hw reset pin synchroniser, held asserted during power-on reset
   // resets to the asserted level so capture waits until the
   // pin has been seen high once and that sample has passed both stages after power-on reset; same
   // depth as the strap path keeps both in step
   always @(posedge clk) begin
      if (rst) begin
         hrst_meta   <= 1'b0;
         hrst_sync_n <= 1'b0;
      end else begin
         hrst_meta   <= hardware_reset_n;
         hrst_sync_n <= hrst_meta;
      end
   end

   // capture sequencing: armed by either reset, fires on release
   // a pin pulse shorter than one cycle may be missed; the
   // board holds the reset pin low far longer than that
   // config_valid drops as soon as the pin is seen low
   // straps and hw reset share synchroniser depth, so the sampled
   // straps are the levels present when the pin went high
   always @(posedge clk) begin
      if (rst) begin
         capture_pending <= 1'b1;
         strap_held      <= {`SCL_STRAP_W{1'b0}};
         config_valid    <= 1'b0;
      end else if (!hrst_sync_n) begin
         capture_pending <= 1'b1;
         config_valid    <= 1'b0;
      end else if (capture_pending) begin
         strap_held      <= pin_sync;
         capture_pending <= 1'b0;
         config_valid    <= 1'b1;
      end
      // otherwise strap_held keeps its value whatever the pins do
   end

   // held strap fields
   // read from the held copy, never the live pins, so later
   // lamp activity cannot reach the configuration
   assign vol_sel = strap_held[`SCL_ST_VOL_HI:`SCL_ST_VOL_LO];
   assign reg_en  = ~strap_held[`SCL_ST_REGDIS];

   // shared pins: released during sampling, leds afterwards
   // a driven pin would override the board resistor and corrupt the strap
   // driving starts on the capture edge itself, together with
   // config_valid: the straps taken there are two cycles old,
   // so the lamps can no longer reach them
   // released again as soon as the hw reset pin is seen low
   always @(posedge clk) begin
      if (rst) begin
         led_out <= 3'h0;
         led_oe  <= 3'h0;
      end else if (!hrst_sync_n) begin
         led_out <= 3'h0;
         led_oe  <= 3'h0;
      end else begin
         led_out <= led_request;
         led_oe  <= 3'h7;
      end
   end

   // decoded configuration outputs, registered
   // every output comes from a flop so consumers see clean
   // levels; they trail the held straps by one cycle, and
   // show reset defaults until the first capture lands
   always @(posedge clk) begin
      if (rst) begin
         mgmt_addr           <= 3'h0;
         rx_clock_delay      <= `SCL_RXD_NONE;
         tx_clock_delay_2ns  <= 1'b0;
         pll_shutdown        <= 1'b0;
         io_regulator_enable <= 1'b1;
         io_voltage          <= `SCL_VOL_3V3;
         io_voltage_invalid  <= 1'b0;
      end else begin
         mgmt_addr <= strap_held[`SCL_ST_ADDR_HI:`SCL_ST_ADDR_LO];
         // speed may change at any time, delay follows it
         rx_clock_delay <= rx_delay_code(strap_held[`SCL_ST_RX], rx_speed);
         tx_clock_delay_2ns <= strap_held[`SCL_ST_TX];
         // pll only stops while actually asleep
         pll_shutdown <= sleep_mode & strap_held[`SCL_ST_PLL];
         io_regulator_enable <= reg_en;
         io_voltage <= vol_code(vol_sel);
         // external supply has no 3.3V option on code 00
         io_voltage_invalid <= ~reg_en & (vol_sel == 2'h0);
      end
   end

   // management address compare
   // the frame address is five bits, the strap only three,
   // so the upper two must be zero for an own match
   // broadcast disable matters only when the strap is not 0
   assign addr_match  = (mgmt_frame_addr ==
                         {2'b00, strap_held[`SCL_ST_ADDR_HI:`SCL_ST_ADDR_LO]});
   assign bcast_match = (mgmt_frame_addr == `SCL_BCAST_ADDR) & ~bcast_disable;

   // answer pulses one cycle after a frame address is offered
   // hit and miss are exclusive and last one cycle; a frame
   // seen while unconfigured is dropped, not queued
   always @(posedge clk) begin
      if (rst) begin
         mgmt_addr_hit  <= 1'b0;
         mgmt_addr_miss <= 1'b0;
      end else if (mgmt_frame_valid && config_valid) begin
         mgmt_addr_hit  <= addr_match | bcast_match;
         mgmt_addr_miss <= ~(addr_match | bcast_match);
      end else begin
         // before capture nothing is answered
         mgmt_addr_hit  <= 1'b0;
         mgmt_addr_miss <= 1'b0;
      end
   end

   // control register write
   // only offset 0 is writable; writes elsewhere are dropped
   // broadcast answering is on again after power-on reset
   always @(posedge clk) begin
      if (rst) begin
         bcast_disable <= ctrl_reset_image[`SCL_CTRL_BCAST_DIS];
      end else if (reg_write && reg_addr == `SCL_OFF_CTRL) begin
         bcast_disable <= reg_wdata[`SCL_CTRL_BCAST_DIS];
      end
   end

   // status views, unused bits read zero
   // the valid flag sits just above the straps so one read
   // shows both the settings and whether they are real
   assign strap_word  = {6'h00, config_valid, strap_held};
   assign effect_word = {8'h00, pll_shutdown, io_voltage_invalid,
                         io_voltage, io_regulator_enable,
                         tx_clock_delay_2ns, rx_clock_delay};

   // read mux, unmapped offsets return zero
   // offsets are decoded in full, so aliases read zero too
   // the views are combinational; the flop below holds the
   // selected word for exactly one cycle
   always @* begin
      next_rdata = {`SCL_DATA_W{1'b0}};
      case (reg_addr)
         `SCL_OFF_CTRL: begin
            next_rdata[`SCL_CTRL_BCAST_DIS] = bcast_disable;
         end
         `SCL_OFF_STRAP: begin
            next_rdata = strap_word;
         end
         `SCL_OFF_EFFECT: begin
            next_rdata = effect_word;
         end
         default: begin
            next_rdata = {`SCL_DATA_W{1'b0}};
         end
      endcase
   end

   // read data stands only in the cycle after the strobe
   // returning to zero lets an or-tree share the read path
   // with other blocks without extra gating, at the cost of
   // the master having to take the word in that one cycle
   always @(posedge clk) begin
      if (rst) begin
         reg_rdata <= {`SCL_DATA_W{1'b0}};
      end else if (reg_read) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= {`SCL_DATA_W{1'b0}};
      end
   end

endmodule

/* dv/scl_board_pulls.sv */
// board pull resistors on the strap pins, three of them shared with the lamps
`timescale 1ns/1ns
module scl_board_pulls (
   input  wire [8:0] pull,
   input  wire [2:0] led_out,
   input  wire [2:0] led_oe,
   output wire [2:0] addr_pin,
   output wire [5:0] misc_pin
);
   // a driven lamp pin overrides its resistor, so late pin changes are real
   assign addr_pin = (led_oe & led_out) | (~led_oe & pull[2:0]);
   // unshared straps only ever see their resistor
   assign misc_pin = pull[8:3];
endmodule

/* dv/scl_strap_latch_properties.sv */
// port-level assertions for the strap latch
`timescale 1ns/1ns
`include "scl_map.vh"
module scl_strap_latch_properties (
   input wire                   clk,
   input wire                   rst,
   input wire                   hardware_reset_n,
   input wire [1:0]             rx_speed,
   input wire                   sleep_mode,
   input wire [4:0]             mgmt_frame_addr,
   input wire                   mgmt_frame_valid,
   input wire                   mgmt_addr_hit,
   input wire                   mgmt_addr_miss,
   input wire [2:0]             mgmt_addr,
   input wire [1:0]             rx_clock_delay,
   input wire                   pll_shutdown,
   input wire                   io_regulator_enable,
   input wire [1:0]             io_voltage,
   input wire                   io_voltage_invalid,
   input wire                   config_valid,
   input wire [2:0]             led_oe,
   input wire                   reg_read,
   input wire [`SCL_DATA_W-1:0] reg_rdata
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // two valid cycles, so the decoded address has landed
   sequence settled_s; config_valid [*2]; endsequence
   sequence own_frame_s; mgmt_frame_valid && mgmt_frame_addr == {2'b00, mgmt_addr}; endsequence
   own_hit_a: assert property (settled_s ##0 own_frame_s |=> mgmt_addr_hit)
      else $error("own address not answered");
   quiet_early_a: assert property (!config_valid |=> !mgmt_addr_hit && !mgmt_addr_miss)
      else $error("answer before capture");
   lamp_enable_a: assert property (led_oe == (config_valid ? 3'h7 : 3'h0))
      else $error("lamp enable wrong");
   capture_hold_a: assert property (hardware_reset_n [*3] ##0 config_valid |=> config_valid)
      else $error("capture lost");
   pll_sleep_a: assert property (!$past(sleep_mode) |-> !pll_shutdown)
      else $error("pll off while awake");
   rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
      else $error("read data without read");
   vol_code_a: assert property (io_voltage != 2'h3 && (!io_voltage_invalid || !io_regulator_enable))
      else $error("voltage code wrong");
   rx_fast_a: assert property ($stable(rx_speed) && rx_clock_delay == 2'h1 |-> rx_speed == 2'h2)
      else $error("2ns delay at low speed");
   rx_slow_a: assert property ($stable(rx_speed) && rx_clock_delay == 2'h2 |-> rx_speed != 2'h2)
      else $error("8ns delay at 125MHz");
endmodule
bind scl_strap_latch scl_strap_latch_properties scl_strap_latch_properties_i (.clk, .rst, .hardware_reset_n,
   .rx_speed, .sleep_mode, .mgmt_frame_addr, .mgmt_frame_valid, .mgmt_addr_hit, .mgmt_addr_miss, .mgmt_addr,
   .rx_clock_delay, .pll_shutdown, .io_regulator_enable, .io_voltage, .io_voltage_invalid, .config_valid,
   .led_oe, .reg_read, .reg_rdata);

/* dv/scl_strap_latch_tb.sv */
// self-checking bench for the strap latch
`timescale 1ns/1ns
`include "scl_map.vh"
module scl_strap_latch_tb;
   reg         clk = 1'b0;
   reg         rst = 1'b1;
   reg         hardware_reset_n = 1'b1;
   reg  [8:0]  pull = 9'h000;
   reg  [8:0]  p;
   reg  [2:0]  led_request = 3'h5;
   reg  [1:0]  rx_speed = 2'h2;
   reg         sleep_mode = 1'b1;
   reg  [4:0]  frame_addr = 5'h00;
   reg         frame_valid = 1'b0;
   reg  [3:0]  reg_addr = 4'h0;
   reg  [15:0] reg_wdata = 16'h0000;
   reg         reg_write = 1'b0;
   reg         reg_read = 1'b0;
   wire [2:0]  led_out, led_oe, addr_pin, mgmt_addr;
   wire [5:0]  misc_pin;
   wire [1:0]  rx_dly, io_voltage;
   wire [15:0] reg_rdata;
   wire        hit, miss, tx_dly, pll_off, reg_en, vol_bad, cfg_ok;
   integer     err_count = 0;
   integer     samples_checked = 0;
   integer     cyc = 0;
   integer     i, j;
   always #5 clk = ~clk;
   // hang guard
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 4000) begin
         err_count = err_count + 1;
         report_and_stop;
      end
   end
   scl_strap_latch scl_strap_latch_i (.clk(clk), .rst(rst), .hardware_reset_n(hardware_reset_n),
      .mgmt_addr_strap(addr_pin), .rx_clock_skew_strap(misc_pin[0]), .tx_clock_skew_strap(misc_pin[1]),
      .sleep_pll_shutdown_strap(misc_pin[2]), .io_regulator_disable_strap(misc_pin[3]),
      .io_voltage_select_strap(misc_pin[5:4]), .led_request(led_request), .led_out(led_out), .led_oe(led_oe),
      .rx_speed(rx_speed), .sleep_mode(sleep_mode), .mgmt_frame_addr(frame_addr), .mgmt_frame_valid(frame_valid),
      .mgmt_addr_hit(hit), .mgmt_addr_miss(miss), .mgmt_addr(mgmt_addr), .rx_clock_delay(rx_dly),
      .tx_clock_delay_2ns(tx_dly), .pll_shutdown(pll_off), .io_regulator_enable(reg_en), .io_voltage(io_voltage),
      .io_voltage_invalid(vol_bad), .config_valid(cfg_ok), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
   scl_board_pulls scl_board_pulls_i (.pull(pull), .led_out(led_out), .led_oe(led_oe), .addr_pin(addr_pin),
      .misc_pin(misc_pin));
   task chk(input [63:0] nm, input [15:0] seen, input [15:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            err_count = err_count + 1;
            $display("ERROR %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task wr(input [3:0] a, input [15:0] d);
      begin
         @(posedge clk);
         reg_addr <= a;
         reg_wdata <= d;
         reg_write <= 1'b1;
         @(posedge clk);
         reg_write <= 1'b0;
      end
   endtask
   // read data stand only in the cycle after the strobe
   task rd(input [3:0] a, input [15:0] exp, input [63:0] nm);
      begin
         @(posedge clk);
         reg_addr <= a;
         reg_read <= 1'b1;
         @(posedge clk);
         reg_read <= 1'b0;
         #1 chk(nm, reg_rdata, exp);
      end
   endtask
   task mg(input [4:0] a, input e);
      begin
         @(posedge clk);
         frame_addr <= a;
         frame_valid <= 1'b1;
         @(posedge clk);
         frame_valid <= 1'b0;
         #1 chk("hit", hit, e);
         chk("miss", miss, !e);
      end
   endtask
   task wait_cfg;
      begin
         repeat (20) if (cfg_ok !== 1'b1) @(posedge clk);
         repeat (2) @(posedge clk);
      end
   endtask
   // straps held steady well before the release edge
   task capture(input [8:0] v);
      begin
         @(posedge clk);
         hardware_reset_n <= 1'b0;
         pull <= v;
         repeat (6) @(posedge clk);
         hardware_reset_n <= 1'b1;
         @(posedge clk);
         chk("lamp_oe", led_oe, 16'h0000);
         chk("cfg", cfg_ok, 16'h0000);
         wait_cfg;
      end
   endtask
   // effect word: [1:0] rx, [2] tx, [3] reg en, [5:4] vol, [6] bad, [7] pll
   function [15:0] eff(input [8:0] v, input [1:0] s);
      eff = {8'h00, v[5] & sleep_mode, v[6] & (v[8:7] == 2'h0),
             (v[8:7] == 2'h0) ? 2'h0 : ((v[8:7] == 2'h1) ? 2'h1 : 2'h2), ~v[6], v[4],
             v[3] ? ((s == 2'h2) ? 2'h1 : 2'h2) : 2'h0};
   endfunction
   task report_and_stop;
      begin
         if (err_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(`SCL_OFF_CTRL, 16'h0000, "ctrl");
      wait_cfg;
      rd(`SCL_OFF_STRAP, 16'h0200, "strap");
      for (i = 0; i < 4; i = i + 1) begin
         p = {i[1:0], i[0], ~i[0], i[1], ~i[1], 3'h7 * i[2:0]};
         sleep_mode <= ~i[0];
         capture(p);
         led_request <= ~p[2:0];
         rd(`SCL_OFF_STRAP, {6'h01, p}, "strap");
         chk("lamp", led_out, {~p[2:0]});
         chk("lamp_oe", led_oe, 16'h0007);
         chk("addr", mgmt_addr, p[2:0]);
         chk("regen", reg_en, !p[6]);
         chk("vol", io_voltage, eff(p, 2'h0) >> 4 & 16'h3);
         chk("tx", tx_dly, p[4]);
         chk("pll", pll_off, p[5] & sleep_mode);
         for (j = 0; j < 4; j = j + 1) begin
            rx_speed <= j[1:0];
            repeat (3) @(posedge clk);
            rd(`SCL_OFF_EFFECT, eff(p, j[1:0]), "effect");
         end
         mg({2'b00, p[2:0]}, 1'b1);
         mg({2'b00, p[2:0] ^ 3'h1}, p[2:0] == 3'h1);
         mg(5'h10, 1'b0);
         mg(5'h00, 1'b1);
         wr(`SCL_OFF_CTRL, 16'h0001);
         rd(`SCL_OFF_CTRL, 16'h0001, "ctrl");
         mg(5'h00, p[2:0] == 3'h0);
         wr(`SCL_OFF_CTRL, 16'h0000);
         wr(`SCL_OFF_STRAP, 16'hffff);
         rd(`SCL_OFF_STRAP, {6'h01, p}, "strap");
         rd(4'hc, 16'h0000, "unmapped");
      end
      report_and_stop;
   end
endmodule
